// ### test/gamma_lut_corrector_bench.sv
// gamma_lut_corrector_bench: random register and stream traffic against a table model
// assumes stream_partner on the stream side and gamma_props bound to the design
module gamma_lut_corrector_bench
    import gamma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic send_en = 1'b0;
    logic [1:0] stall_lvl = 2'h1;
    reg_req_t reg_req = '0;
    logic [SAMPLE_W-1:0] reg_rdata;
    logic reg_rdata_valid, in_ready, out_ready;
    sample_t in_sample, out_sample;
    logic [SAMPLE_W-1:0] lut_m [LUT_DEPTH];
    logic [SAMPLE_W-1:0] exp_q [$];
    logic go_m = 1'b0;
    logic [ADDR_W-1:0] a_list [5] = '{10'h000, 10'h05c, 10'h101, 10'h102, 10'h3ff};
    int bad_count = 0, n_tests = 0, takes = 0;
    gamma_lut_corrector #(.FRAME_W(2), .FRAME_H(2), .PLANES(1)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .in_sample(in_sample), .in_ready(in_ready),
        .out_sample(out_sample), .out_ready(out_ready));
    stream_partner up_down (.core_clk(core_clk), .sys_rst(sys_rst), .send_en(send_en),
        .stall_lvl(stall_lvl), .in_ready(in_ready), .in_sample(in_sample), .out_ready(out_ready));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic complete_run;
        $display("mismatches %0d, checks %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    function automatic logic [SAMPLE_W-1:0] exp_reg(input logic [ADDR_W-1:0] a);
        if (a == RUN_CONTROL_ADDR) return SAMPLE_W'(go_m);
        if (a >= LUT_BASE_ADDR && a <= LUT_LAST_ADDR) return lut_m[a - LUT_BASE_ADDR];
        return '0;
    endfunction : exp_reg
    // one strobe per access; for a read, val is the expected answer
    task automatic reg_access(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] val);
        @(posedge core_clk);
        reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: val};
        @(posedge core_clk);
        reg_req <= '0;
        if (wr && a == RUN_CONTROL_ADDR) go_m = val[GO_BIT];
        if (wr && a >= LUT_BASE_ADDR && a <= LUT_LAST_ADDR) lut_m[a - LUT_BASE_ADDR] = val;
        #1;
        if (!wr) check(reg_rdata_valid === 1'b1 && reg_rdata === val, "read mismatch");
    endtask : reg_access
    // falling edge sees the settled handshake that the next rising edge takes
    always @(negedge core_clk) begin
        if (!sys_rst && out_sample.valid && out_ready) begin
            check(exp_q.size() > 0 && out_sample.data === exp_q[0], "wrong sample");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
        if (!sys_rst && in_ready && in_sample.valid) begin
            exp_q.push_back(lut_m[in_sample.data]);
            takes++;
        end
    end
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
    initial begin
        logic [ADDR_W-1:0] a;
        int t;
        void'($urandom(25));
        foreach (lut_m[i]) lut_m[i] = SAMPLE_W'(i);
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_access(1'b0, RUN_STATUS_ADDR, 8'h00);
        reg_access(1'b1, LUT_LAST_ADDR + 10'h001, 8'h77);
        reg_access(1'b1, RUN_STATUS_ADDR, 8'hff);
        reg_access(1'b1, LUT_LAST_ADDR, 8'hc3);
        foreach (a_list[i]) reg_access(1'b0, a_list[i], exp_reg(a_list[i]));
        for (int i = 0; i < LUT_DEPTH; i++) begin
            reg_access(1'b1, LUT_BASE_ADDR + ADDR_W'(i), 8'($urandom));
        end
        reg_access(1'b1, RUN_CONTROL_ADDR, 8'hff);
        reg_access(1'b0, RUN_CONTROL_ADDR, 8'h01);
        reg_access(1'b0, RUN_STATUS_ADDR, 8'h01);
        send_en <= 1'b1;
        repeat (150) begin
            stall_lvl <= 2'($urandom);
            a = LUT_BASE_ADDR + ADDR_W'(8'($urandom));
            reg_access(1'b1, a, 8'($urandom));
            reg_access(1'b0, a, exp_reg(a));
        end
        stall_lvl <= 2'h0;
        reg_access(1'b1, RUN_CONTROL_ADDR, 8'h00);
        repeat (60) @(posedge core_clk);
        t = takes;
        reg_access(1'b0, RUN_STATUS_ADDR, 8'h00);
        reg_access(1'b1, LUT_BASE_ADDR + 10'h010, 8'h11);
        check(takes == t && takes % 4 == 0, "take after stop");
        reg_access(1'b1, RUN_CONTROL_ADDR, 8'h01);
        repeat (40) @(posedge core_clk);
        check(takes > t, "no resume");
        send_en <= 1'b0;
        repeat (40) @(posedge core_clk);
        check(exp_q.size() == 0, "lost samples");
        complete_run();
    end
endmodule : gamma_lut_corrector_bench

// ### test/gamma_props_properties.sv
// gamma_props: port checks for the gamma corrector
// assumes one clock and a synchronous reset
module gamma_props
    import gamma_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire reg_req_t reg_req,
    input wire logic [SAMPLE_W-1:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire sample_t in_sample,
    input wire logic in_ready,
    input wire sample_t out_sample,
    input wire logic out_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic take = in_ready && in_sample.valid;
    wire logic rd_low = reg_req.rd && reg_req.addr < LUT_BASE_ADDR;
    wire logic rd_off = reg_req.rd && reg_req.addr > LUT_LAST_ADDR;
    // register answers: one cycle late, never unasked, unused bits zero
    property p_ans; reg_req.rd |=> reg_rdata_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_quiet; !reg_req.rd |=> !reg_rdata_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_upper; rd_low |=> reg_rdata[SAMPLE_W-1:1] == '0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_off; rd_off |=> reg_rdata == '0; endproperty
    a_off: assert property (p_off) else $error("unmapped data");
    // stream: single slot, held output, answer one cycle after a take
    property p_hold;
        out_sample.valid && !out_ready |=> out_sample.valid && $stable(out_sample.data);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_drop; take |=> !in_ready; endproperty
    a_drop: assert property (p_drop) else $error("ready held");
    property p_out; take |=> out_sample.valid; endproperty
    a_out: assert property (p_out) else $error("no output");
    property p_idle; !take && (!out_sample.valid || out_ready) |=> !out_sample.valid; endproperty
    a_idle: assert property (p_idle) else $error("output from nothing");
    c_take: cover property (take);
    c_stall: cover property (out_sample.valid && !out_ready);
    c_low: cover property (rd_low);
    c_drain: cover property (out_sample.valid && out_ready);
endmodule : gamma_props

bind gamma_lut_corrector gamma_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .in_sample(in_sample), .in_ready(in_ready), .out_sample(out_sample), .out_ready(out_ready));

// ### test/stream_partner.sv
// stream_partner: upstream source and downstream sink of the sample stream
// assumes core_clk; the bench seeds the generator once
module stream_partner
    import gamma_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic send_en,
    input wire logic [1:0] stall_lvl,
    input wire logic in_ready,
    output sample_t in_sample,
    output logic out_ready
);
    // idle data toggles every cycle while send_en is low, and is fresh random data after a take, so a stale value can never pass for a sample
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            in_sample <= '0;
            out_ready <= 1'b0;
        end else begin
            out_ready <= 2'($urandom) >= stall_lvl;
            if ((in_ready && in_sample.valid) || !in_sample.valid) begin
                in_sample <= '{valid: send_en && !in_sample.valid,
                               data: send_en ? SAMPLE_W'($urandom) : ~in_sample.data};
            end
        end
    end
endmodule : stream_partner

// ### verilog/gamma_lut_corrector.sv
// gamma_lut_corrector: replaces each colour-plane sample by its table entry
// assumes upstream and downstream logic on core_clk using valid/ready handshakes,
// and a controller writing the registers through the word-addressed slave port
//
// Functional notes
// - Frame width is a compile-time parameter, 32 to 1920 pixels, default 640.
// - Frame height is a compile-time parameter, 32 to 1080 lines, default 480.
// - Sample width per plane is a compile-time constant, 4 to 16 bits, default 8.
// - One to three planes travel in sequence on one data connection.
// - Control, status and table are reached only through the memory-mapped slave port.
// - Table writes take effect on the very next sample, even mid-frame.
// - Every register is exactly one sample wide.
// - Address 0 holds the run-enable bit in bit 0, other bits unused.
// - Writing zero to address 0 stops processing at the next frame boundary.
// - Address 1 shows the running status in bit 0, other bits unused.
// - Table entries sit at 2 to 2^N+1 and sample x is replaced by entry x+2.
module gamma_lut_corrector
    import gamma_pkg::*;
#(
    parameter int FRAME_W = DEF_FRAME_W,
    parameter int FRAME_H = DEF_FRAME_H,
    parameter int PLANES = DEF_PLANES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire reg_req_t reg_req,
    output logic [SAMPLE_W-1:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire sample_t in_sample,
    output logic in_ready,
    output sample_t out_sample,
    input wire logic out_ready
);
    localparam logic [CNT_W-1:0] LAST_SAMPLE = CNT_W'(FRAME_W * FRAME_H * PLANES - 1);

    run_state_t state_reg, state_next;
    logic go_reg, go_next;
    logic [CNT_W-1:0] pos_reg, pos_next;
    logic [SAMPLE_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg;
    logic in_ready_reg, in_ready_next;
    sample_t out_reg, out_next;

    // register decode; address range checks keep unmapped words harmless
    wire logic hit_ctrl = reg_req.addr == RUN_CONTROL_ADDR;
    wire logic hit_stat = reg_req.addr == RUN_STATUS_ADDR;
    wire logic hit_lut = (reg_req.addr >= LUT_BASE_ADDR) &&
                         (reg_req.addr <= LUT_LAST_ADDR);
    wire logic [ADDR_W-1:0] lut_off = reg_req.addr - LUT_BASE_ADDR;
    wire logic [SAMPLE_W-1:0] lut_idx = lut_off[SAMPLE_W-1:0];
    wire logic lut_wr = reg_req.wr && hit_lut;
    wire logic [SAMPLE_W-1:0] pix_val;
    wire logic [SAMPLE_W-1:0] bus_val;

    // stream handshakes
    wire logic accept = in_ready_reg && in_sample.valid;
    wire logic drained = out_reg.valid && out_ready;
    wire logic frame_end = accept && (pos_reg == LAST_SAMPLE);
    wire logic running = state_reg == ST_RUNNING;

    gamma_lut_store u_lut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(lut_wr),
        .wr_idx(lut_idx),
        .wr_data(reg_req.wdata),
        .pix_idx(in_sample.data),
        .bus_idx(lut_idx),
        .pix_val(pix_val),
        .bus_val(bus_val)
    );

    // run-enable bit; only bit 0 is stored, the rest of the word is dropped
    assign go_next = (reg_req.wr && hit_ctrl) ? reg_req.wdata[GO_BIT] : go_reg;

    // run/stop sequencing; go starts a run at once but stops it only on a frame boundary
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STOPPED: begin
                if (go_reg) begin
                    state_next = ST_RUNNING;
                end
            end
            ST_RUNNING: begin
                if (frame_end && !go_reg) begin
                    state_next = ST_STOPPED;
                end
            end
        endcase
    end

    // sample position within the frame, planes counted as separate samples
    assign pos_next = !accept ? pos_reg :
                      frame_end ? CNT_RESET : pos_reg + CNT_W'(1);

    // one output slot; ready is registered, which caps throughput at one
    // sample every other cycle but keeps every port straight from a flop
    always_comb begin
        out_next = out_reg;
        if (drained) begin
            out_next.valid = 1'b0;
        end
        if (accept) begin
            out_next.valid = 1'b1;
            out_next.data = pix_val;
        end
    end
    assign in_ready_next = (state_next == ST_RUNNING) && !out_next.valid;

    // read data: control and status show bit 0 only, unmapped words read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_req.rd) begin
            rdata_next = RDATA_RESET;
            if (hit_ctrl) begin
                rdata_next[GO_BIT] = go_reg;
            end else if (hit_stat) begin
                rdata_next[STATUS_BIT] = running;
            end else if (hit_lut) begin
                rdata_next = bus_val;
            end
        end
    end

    // state registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_STOPPED;
            go_reg <= GO_RESET;
            pos_reg <= CNT_RESET;
            in_ready_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            state_reg <= state_next;
            go_reg <= go_next;
            pos_reg <= pos_next;
            in_ready_reg <= in_ready_next;
            out_reg <= out_next;
        end
    end

    // slave read answer, one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= RDATA_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= reg_req.rd;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rdata_valid = rvalid_reg;
    assign in_ready = in_ready_reg;
    assign out_sample = out_reg;
endmodule : gamma_lut_corrector

// ### verilog/gamma_lut_store.sv
// gamma_lut_store: flip-flop look-up table, one write port, two read ports
// assumes writes come from the register slave and the stream reads in parallel
module gamma_lut_store
    import gamma_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [SAMPLE_W-1:0] wr_idx,
    input wire logic [SAMPLE_W-1:0] wr_data,
    input wire logic [SAMPLE_W-1:0] pix_idx,
    input wire logic [SAMPLE_W-1:0] bus_idx,
    output logic [SAMPLE_W-1:0] pix_val,
    output logic [SAMPLE_W-1:0] bus_val
);
    logic [SAMPLE_W-1:0] table_reg [LUT_DEPTH];

    // reset loads an identity curve so an unloaded table passes video through
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < LUT_DEPTH; i++) begin
                table_reg[i] <= SAMPLE_W'(i);
            end
        end else if (wr_en) begin
            table_reg[wr_idx] <= wr_data;
        end
    end

    // read ports are combinational, so a write is seen by the very next sample
    assign pix_val = table_reg[pix_idx];
    assign bus_val = table_reg[bus_idx];
endmodule : gamma_lut_store

// ### verilog/gamma_pkg.sv
// gamma_pkg: shared constants, carriers and state codes for the gamma corrector
// assumes one clock domain; sample width is fixed here at compile time
package gamma_pkg;
    // per-plane sample width, also the width of every control register
    localparam int SAMPLE_W = 8;
    localparam int LUT_DEPTH = 1 << SAMPLE_W;
    localparam int ADDR_W = SAMPLE_W + 2;
    // frame geometry defaults
    localparam int DEF_FRAME_W = 640;
    localparam int DEF_FRAME_H = 480;
    localparam int DEF_PLANES = 3;
    localparam int CNT_W = 23;
    // register map, word addresses on the slave port
    localparam logic [ADDR_W-1:0] RUN_CONTROL_ADDR = ADDR_W'(0);
    localparam logic [ADDR_W-1:0] RUN_STATUS_ADDR = ADDR_W'(1);
    localparam logic [ADDR_W-1:0] LUT_BASE_ADDR = ADDR_W'(2);
    localparam logic [ADDR_W-1:0] LUT_LAST_ADDR = ADDR_W'(LUT_DEPTH + 1);
    // field positions and reset values
    localparam int GO_BIT = 0;
    localparam int STATUS_BIT = 0;
    localparam logic GO_RESET = 1'h0;
    localparam logic [SAMPLE_W-1:0] RDATA_RESET = SAMPLE_W'(0);
    localparam logic [CNT_W-1:0] CNT_RESET = CNT_W'(0);

    // one access on the register slave port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [SAMPLE_W-1:0] wdata;
    } reg_req_t;

    // one sample of the colour-plane stream
    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } sample_t;

    typedef enum logic [0:0] {
        ST_STOPPED = 1'b0,
        ST_RUNNING = 1'b1
    } run_state_t;
endpackage : gamma_pkg
